// *** hw/adc_scan_sequencer.sv ***
// Scan sequencer for a dual-converter ADC with an AHB-Lite register slave
// Notes on behaviour
// - Eight sample slots; a scan converts each slot's input and stores it.
// - A slot whose disable bit is 1 is unused; the scan ends there.
// - Inputs of a pair set differential are measured differentially.
// - Mode field picks one 8-slot or two 4-slot scans, start, end, repeat.
// - The lockstep bit matters only in parallel modes.
// - Lockstep: both follow control A; otherwise B follows control B.
// - Sequential scan runs from slot 0 to first disabled slot or slot 7.
// - Once modes: after a sync start, syncs ignored until control A written.
// - Once, independent parallel: B re-armed only by writing control B.
// - Parallel: converter A takes slots 0-3, converter B slots 4-7.
// - Lockstep: both stop when either hits a disabled slot or both finish.
// - Independent: each stops on its own disabled slot or after 4 slots.
// - Loop sequential repeats until the A halt bit is set.
// - While a loop scan runs, starts and syncs are ignored.
// - Loop parallel: each converter restarts at once until its halt bit.
// - Auto power modes: power-up delay only before the first loop pass.
// - Triggered sequential: a sync during a scan is not acted on.
// - Triggered parallel is the reset mode; syncs start only when idle.
// - Sync rising edge starts only if enabled; start bit also starts.
// - A set halt bit stops the converter's scan and blocks new starts.
// - A finished scan raises end-of-scan, gated by its enable bit.
// - Re-arming by a control write works at any time, even mid-scan.
`timescale 1ns/10ps

module adc_scan_sequencer
  import adc_scan_pkg::*;
#(
  parameter int unsigned RES_W = CONV_W
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  input  wire logic        i_sync_a,
  input  wire logic        i_sync_b,
  input  wire conv_rsp_t   i_conv_a,
  input  wire conv_rsp_t   i_conv_b,
  output conv_req_t        o_conv_a,
  output conv_req_t        o_conv_b,
  output logic             o_cip_a,
  output logic             o_cip_b,
  output logic             o_eos_irq_a,
  output logic             o_eos_irq_b
);

  // ==========================================================================
  // Elaboration check
  if (RES_W < 1 || RES_W > CONV_W) begin : g_bad_res_w
    $error("RES_W must lie between 1 and the converter width");
  end

  // ==========================================================================
  // State
  typedef struct packed {
    scan_mode_t                       mode;
    logic [3:0]                       pair_cfg;
    logic                             sync_en_a;
    logic                             halt_a;
    logic                             eosie_a;
    logic                             lockstep;
    logic                             sync_en_b;
    logic                             halt_b;
    logic                             eosie_b;
    logic [SLOT_N-1:0][IN_W-1:0]      slot_in;
    logic [SLOT_N-1:0]                slot_dis;
    logic                             auto_standby_bit;
    logic                             auto_powerdown_bit;
    logic [PUD_W-1:0]                 pud;
    logic [1:0]                       armed;
    logic [1:0]                       eos;
    logic [1:0]                       sync_s1;
    logic [1:0]                       sync_s2;
    logic [1:0]                       sync_s3;
    eng_t [1:0]                       eng;
    logic [SLOT_N-1:0][RES_W-1:0]     result;
    logic [ADDR_W-1:0]                addr;
    logic                             rd_pend;
    logic                             rd_ok;
    logic                             wr_pend;
    logic [31:0]                      hrdata;
  } state_t;

  state_t q;
  state_t d;

  // ==========================================================================
  // Decoding helpers
  function automatic logic is_par(input scan_mode_t m);
    return m == MODE_ONCE_PAR || m == MODE_LOOP_PAR || m == MODE_TRIG_PAR;
  endfunction

  // Slot ends the scan; lockstep also checks the partner slot
  function automatic logic slot_off(input state_t s,
                                    input logic [IN_W-1:0] slot,
                                    input logic both);
    return s.slot_dis[slot] | (both & s.slot_dis[slot + 3'h4]);
  endfunction

  // Parallel halves may only reach their own four inputs
  function automatic logic [IN_W-1:0] chan_of(input state_t s,
                                              input logic [IN_W-1:0] slot,
                                              input logic par);
    logic [IN_W-1:0] c;
    c = s.slot_in[slot];
    if (par) begin
      c[2] = slot[2];
    end
    return c;
  endfunction

  function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [ADDR_W-1:0] a);
    logic [31:0] r;
    r = 32'h0000_0000;
    if (a == OFS_CTRL_A[7:2]) begin
      r[CA_MODE_LSB +: 3] = s.mode;
      r[CA_PAIR_LSB +: 4] = s.pair_cfg;
      r[CA_SYNC_EN]       = s.sync_en_a;
      r[CA_HALT]          = s.halt_a;
      r[CA_EOSIE]         = s.eosie_a;
    end else if (a == OFS_CTRL_B[7:2]) begin
      r[CB_LOCK]    = s.lockstep;
      r[CB_SYNC_EN] = s.sync_en_b;
      r[CB_HALT]    = s.halt_b;
      r[CB_EOSIE]   = s.eosie_b;
    end else if (a == OFS_LIST_L[7:2] || a == OFS_LIST_H[7:2]) begin
      for (int k = 0; k < HALF_N; k++) begin
        r[k*LIST_PITCH +: IN_W] = s.slot_in[{a[0], 2'(k)}];
      end
    end else if (a == OFS_DIS[7:2]) begin
      r[SLOT_N-1:0] = s.slot_dis;
    end else if (a == OFS_POWER[7:2]) begin
      r[PW_ASB]                = s.auto_standby_bit;
      r[PW_APD]                = s.auto_powerdown_bit;
      r[PW_PUD_LSB +: PUD_W]   = s.pud;
    end else if (a == OFS_STATUS[7:2]) begin
      r[ST_CIP_A] = s.eng[0].st != E_IDLE;
      r[ST_CIP_B] = s.eng[1].st != E_IDLE ||
                    (is_par(s.mode) && s.lockstep && s.eng[0].st != E_IDLE);
      r[ST_EOS_A] = s.eos[0];
      r[ST_EOS_B] = s.eos[1];
      r[ST_ARM_A] = s.armed[0];
      r[ST_ARM_B] = s.armed[1];
    end else if (a[ADDR_W-1:3] == OFS_RES0[7:5]) begin
      // Left justified like the converter word, sign-free
      r[RES_SHIFT + CONV_W - RES_W +: RES_W] = s.result[a[2:0]];
    end
    return r;
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    logic       par;
    logic       lockstep_parallel_bit;
    logic       indep;
    logic       once;
    logic       loop;
    logic       wr_a;
    logic       wr_b;
    logic       wr_st;
    logic [1:0] start;
    logic [1:0] rise;
    logic [1:0] trig;
    logic [1:0] halt;
    logic [1:0] active;
    logic [1:0] eos_set;
    logic [1:0] arm_clr;
    logic [IN_W-1:0] base;
    logic [IN_W-1:0] last;
    logic       need_b;
    logic       done_me;
    logic       finish;
    eng_t       e;
    eng_t       ne;
    d       = q;
    par     = is_par(q.mode);
    lockstep_parallel_bit  = par & q.lockstep;
    indep   = par & ~q.lockstep;
    once    = q.mode == MODE_ONCE_SEQ || q.mode == MODE_ONCE_PAR;
    loop    = q.mode == MODE_LOOP_SEQ || q.mode == MODE_LOOP_PAR;
    wr_a    = q.wr_pend && q.addr == OFS_CTRL_A[7:2];
    wr_b    = q.wr_pend && q.addr == OFS_CTRL_B[7:2];
    wr_st   = q.wr_pend && q.addr == OFS_STATUS[7:2];
    start   = {wr_b & i_hwdata[CB_START], wr_a & i_hwdata[CA_START]};
    eos_set = 2'h0;
    arm_clr = 2'h0;
    // Sync pins: two stages, edge taken past the second
    d.sync_s1 = {i_sync_b, i_sync_a};
    d.sync_s2 = q.sync_s1;
    d.sync_s3 = q.sync_s2;
    rise      = q.sync_s2 & ~q.sync_s3;
    trig[0]   = start[0] | (rise[0] & q.sync_en_a &
                            (~once | q.armed[0]));
    trig[1]   = start[1] | (rise[1] & q.sync_en_b &
                            (~once | q.armed[1]));
    halt      = {wr_b ? i_hwdata[CB_HALT] : q.halt_b,
                 wr_a ? i_hwdata[CA_HALT] : q.halt_a};
    active    = {indep, 1'b1};

    // ========================================================================
    // Scan engines
    for (int n = 0; n < 2; n++) begin
      e       = q.eng[n];
      ne      = e;
      finish  = 1'b0;
      base    = (n == 1) ? 3'h4 : 3'h0;
      last    = par ? base + 3'h3 : 3'h7;
      need_b  = lockstep_parallel_bit && n == 0;
      done_me = (n == 0) ? i_conv_a.done : i_conv_b.done;
      unique case (e.st)
        E_IDLE: begin
          // Busy engines never look at triggers
          if (trig[n] && !halt[n] && active[n]) begin
            arm_clr[n] = once & ~start[n];
            ne.slot  = base;
            ne.got_a = 1'b0;
            ne.got_b = 1'b0;
            if ((q.auto_standby_bit || q.auto_powerdown_bit) && q.pud != '0) begin
              ne.st  = E_PWRUP;
              ne.cnt = q.pud;
            end else begin
              ne.st  = E_CONV;
            end
          end
        end
        E_PWRUP: begin
          if (e.cnt <= PUD_W'(1)) begin
            ne.st = E_CONV;
          end else begin
            ne.cnt = e.cnt - PUD_W'(1);
          end
        end
        E_CONV: begin
          if (slot_off(q, e.slot, need_b)) begin
            finish = 1'b1;
          end else begin
            if (done_me) begin
              ne.got_a = 1'b1;
              d.result[e.slot] = (n == 0) ?
                i_conv_a.data[CONV_W-1 -: RES_W] :
                i_conv_b.data[CONV_W-1 -: RES_W];
            end
            if (need_b && i_conv_b.done) begin
              ne.got_b = 1'b1;
              d.result[e.slot + 3'h4] =
                i_conv_b.data[CONV_W-1 -: RES_W];
            end
            // Lockstep waits for both converters before stepping
            if (ne.got_a && (ne.got_b || !need_b)) begin
              ne.got_a = 1'b0;
              ne.got_b = 1'b0;
              if (e.slot == last) begin
                finish = 1'b1;
              end else begin
                ne.slot = e.slot + 3'h1;
              end
            end
          end
        end
        default: begin
          ne.st = E_IDLE;
        end
      endcase
      if (finish) begin
        eos_set[n] = 1'b1;
        ne.slot    = base;
        ne.got_a   = 1'b0;
        ne.got_b   = 1'b0;
        // Loop passes skip the power-up wait
        ne.st      = loop ? E_CONV : E_IDLE;
      end
      if (halt[n] || !active[n]) begin
        ne.st    = E_IDLE;
        ne.got_a = 1'b0;
        ne.got_b = 1'b0;
      end
      d.eng[n] = ne;
    end

    // ========================================================================
    // Register writes
    d.armed = q.armed & ~arm_clr;
    if (wr_a) begin
      d.mode      = scan_mode_t'(i_hwdata[CA_MODE_LSB +: 3]);
      d.pair_cfg  = i_hwdata[CA_PAIR_LSB +: 4];
      d.sync_en_a = i_hwdata[CA_SYNC_EN];
      d.halt_a    = i_hwdata[CA_HALT];
      d.eosie_a   = i_hwdata[CA_EOSIE];
      d.armed[0]  = 1'b1;
    end
    if (wr_b) begin
      d.lockstep  = i_hwdata[CB_LOCK];
      d.sync_en_b = i_hwdata[CB_SYNC_EN];
      d.halt_b    = i_hwdata[CB_HALT];
      d.eosie_b   = i_hwdata[CB_EOSIE];
      d.armed[1]  = 1'b1;
    end
    if (q.wr_pend && (q.addr == OFS_LIST_L[7:2] ||
                      q.addr == OFS_LIST_H[7:2])) begin
      for (int k = 0; k < HALF_N; k++) begin
        d.slot_in[{q.addr[0], 2'(k)}] = i_hwdata[k*LIST_PITCH +: IN_W];
      end
    end
    if (q.wr_pend && q.addr == OFS_DIS[7:2]) begin
      d.slot_dis = i_hwdata[SLOT_N-1:0];
    end
    if (q.wr_pend && q.addr == OFS_POWER[7:2]) begin
      d.auto_standby_bit = i_hwdata[PW_ASB];
      d.auto_powerdown_bit = i_hwdata[PW_APD];
      d.pud = i_hwdata[PW_PUD_LSB +: PUD_W];
    end
    if (wr_st) begin
      d.eos = q.eos & ~{i_hwdata[ST_EOS_B], i_hwdata[ST_EOS_A]};
    end
    // A finishing scan beats a clear in the same cycle
    d.eos = d.eos | eos_set;

    // ========================================================================
    // AHB-Lite slave: writes zero-wait, reads one wait state
    d.wr_pend = 1'b0;
    if (q.rd_pend && !q.rd_ok) begin
      d.hrdata = reg_read(q, q.addr);
      d.rd_ok  = 1'b1;
    end else if (q.rd_pend) begin
      d.rd_pend = 1'b0;
      d.rd_ok   = 1'b0;
    end
    if (i_hsel && i_hready && i_htrans[1]) begin
      d.addr    = i_haddr[ADDR_W+1:2];
      d.wr_pend = i_hwrite;
      d.rd_pend = ~i_hwrite;
      d.rd_ok   = 1'b0;
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      q            <= '0;
      q.mode       <= RST_MODE;
      q.lockstep   <= RST_LOCK;
      q.armed      <= RST_ARMED;
      q.eng[0].st  <= E_IDLE;
      q.eng[1].st  <= E_IDLE;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // Outputs
  always_comb begin
    logic par;
    logic lockstep_parallel_bit;
    logic indep;
    par    = is_par(q.mode);
    lockstep_parallel_bit = par & q.lockstep;
    indep  = par & ~q.lockstep;
    o_conv_a.req  = q.eng[0].st == E_CONV && !q.eng[0].got_a &&
                    !slot_off(q, q.eng[0].slot, lockstep_parallel_bit);
    o_conv_a.slot = q.eng[0].slot;
    o_conv_a.chan = chan_of(q, q.eng[0].slot, par);
    o_conv_a.diff = q.pair_cfg[o_conv_a.chan[2:1]];
    o_conv_b = '0;
    if (lockstep_parallel_bit) begin
      o_conv_b.req  = q.eng[0].st == E_CONV && !q.eng[0].got_b &&
                      !slot_off(q, q.eng[0].slot, 1'b1);
      o_conv_b.slot = q.eng[0].slot + 3'h4;
    end else if (indep) begin
      o_conv_b.req  = q.eng[1].st == E_CONV && !q.eng[1].got_a &&
                      !slot_off(q, q.eng[1].slot, 1'b0);
      o_conv_b.slot = q.eng[1].slot;
    end
    o_conv_b.chan = chan_of(q, o_conv_b.slot, 1'b1);
    o_conv_b.diff = q.pair_cfg[o_conv_b.chan[2:1]];
    o_cip_a = q.eng[0].st != E_IDLE;
    o_cip_b = (indep && q.eng[1].st != E_IDLE) ||
              (lockstep_parallel_bit && q.eng[0].st != E_IDLE);
  end

  assign o_eos_irq_a = q.eos[0] & q.eosie_a;
  assign o_eos_irq_b = q.eos[1] & q.eosie_b;
  assign o_hreadyout = ~(q.rd_pend & ~q.rd_ok);
  assign o_hresp     = 1'b0;
  assign o_hrdata    = q.hrdata;

endmodule

// *** hw/adc_scan_pkg.sv ***
// Package: register map, field layout, resets and carriers of the scan sequencer
package adc_scan_pkg;

  // ==========================================================================
  // Sizes
  localparam int unsigned SLOT_N    = 8;
  localparam int unsigned HALF_N    = 4;
  localparam int unsigned IN_W      = 3;
  localparam int unsigned CONV_W    = 12;
  localparam int unsigned PUD_W     = 8;
  localparam int unsigned ADDR_W    = 6;
  localparam int unsigned RES_SHIFT = 3;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL_A = 8'h00;  // control_a_reg
  localparam logic [7:0] OFS_CTRL_B = 8'h04;  // control_b_reg
  localparam logic [7:0] OFS_LIST_L = 8'h08;  // slot_list_low
  localparam logic [7:0] OFS_LIST_H = 8'h0C;  // slot_list_high
  localparam logic [7:0] OFS_DIS    = 8'h10;  // slot_disable_reg
  localparam logic [7:0] OFS_POWER  = 8'h14;
  localparam logic [7:0] OFS_STATUS = 8'h18;
  localparam logic [7:0] OFS_RES0   = 8'h20;  // results, one word each

  // ==========================================================================
  // Field positions
  localparam int unsigned CA_MODE_LSB = 0;   // scan_mode_field, 3 bits
  localparam int unsigned CA_PAIR_LSB = 4;   // pair_config_field, 4 bits
  localparam int unsigned CA_SYNC_EN  = 8;   // trigger_a_enable
  localparam int unsigned CA_START    = 9;   // write 1 to start
  localparam int unsigned CA_HALT     = 10;  // halt_a_bit
  localparam int unsigned CA_EOSIE    = 11;
  localparam int unsigned CB_LOCK     = 0;   // lockstep_parallel_bit
  localparam int unsigned CB_SYNC_EN  = 1;
  localparam int unsigned CB_START    = 2;
  localparam int unsigned CB_HALT     = 3;
  localparam int unsigned CB_EOSIE    = 4;
  localparam int unsigned LIST_PITCH  = 4;   // one slot per nibble
  localparam int unsigned PW_ASB      = 0;
  localparam int unsigned PW_APD      = 1;
  localparam int unsigned PW_PUD_LSB  = 8;
  localparam int unsigned ST_CIP_A    = 0;
  localparam int unsigned ST_CIP_B    = 1;
  localparam int unsigned ST_EOS_A    = 2;   // write 1 to clear
  localparam int unsigned ST_EOS_B    = 3;   // write 1 to clear
  localparam int unsigned ST_ARM_A    = 4;
  localparam int unsigned ST_ARM_B    = 5;

  // ==========================================================================
  // Scan modes and reset values
  typedef enum logic [2:0] {
    MODE_ONCE_SEQ = 3'h0,
    MODE_ONCE_PAR = 3'h1,
    MODE_LOOP_SEQ = 3'h2,
    MODE_LOOP_PAR = 3'h3,
    MODE_TRIG_SEQ = 3'h4,
    MODE_TRIG_PAR = 3'h5
  } scan_mode_t;

  localparam scan_mode_t RST_MODE  = MODE_TRIG_PAR;
  localparam logic       RST_LOCK  = 1'b1;
  localparam logic [1:0] RST_ARMED = 2'h3;

  // ==========================================================================
  // Per-converter scan engine
  typedef enum logic [2:0] {
    E_IDLE  = 3'b001,
    E_PWRUP = 3'b010,
    E_CONV  = 3'b100
  } eng_state_t;

  typedef struct packed {
    eng_state_t         st;
    logic [IN_W-1:0]    slot;
    logic [PUD_W-1:0]   cnt;
    logic               got_a;
    logic               got_b;
  } eng_t;

  // ==========================================================================
  // Converter carriers
  typedef struct packed {
    logic            req;
    logic [IN_W-1:0] slot;
    logic [IN_W-1:0] chan;
    logic            diff;
  } conv_req_t;

  typedef struct packed {
    logic              done;
    logic [CONV_W-1:0] data;
  } conv_rsp_t;

endpackage

// *** testbench/adc_scan_checker.sv ***
// Checker: bus timing and scan step relations at the sequencer ports
`timescale 1ns/10ps
module adc_scan_checker
  import adc_scan_pkg::*;
(
  input wire logic        i_sys_clk,
  input wire logic        i_rst,
  input wire logic        i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic [31:0] i_hwdata,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire conv_rsp_t   i_conv_a,
  input wire conv_req_t   o_conv_a,
  input wire conv_req_t   o_conv_b,
  input wire logic        o_cip_a,
  input wire logic        o_eos_irq_a
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  // ==========
  // Bus phases
  sequence s_read;
    i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  endsequence
  sequence s_write;
    i_hsel && i_hready && i_htrans[1] && i_hwrite;
  endsequence
  sequence s_ctrl_a(int b);
    s_write ##0 i_haddr[7:2] == 6'h00 ##1 i_hwdata[b];
  endsequence

  // ==========
  // Assertions
  a_read_wait: assert property (s_read |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read answer timing wrong");
  a_write_fast: assert property (s_write |=> o_hreadyout)
    else $error("write wait state seen");
  a_req_busy: assert property (o_conv_a.req |-> o_cip_a)
    else $error("request outside a scan");
  // A halt may drop the request early, but only together with the scan
  a_req_hold: assert property (o_conv_a.req && !i_conv_a.done |=>
    (o_conv_a.req && $stable(o_conv_a.slot)) || !o_cip_a)
    else $error("request dropped before answer");
  a_slot_next: assert property (o_conv_a.req && $past(o_conv_a.req) &&
    $changed(o_conv_a.slot) |-> o_conv_a.slot == $past(o_conv_a.slot)
    + 3'h1 || o_conv_a.slot == 3'h0) else $error("slot order broken");
  a_b_upper: assert property (o_conv_b.req |-> o_conv_b.slot[2] &&
    o_conv_b.chan[2]) else $error("converter B outside its half");
  a_start_run: assert property (s_ctrl_a(CA_START) ##0
    !i_hwdata[CA_HALT] |-> ##[1:2] o_cip_a) else $error("start lost");
  a_halt_stop: assert property (s_ctrl_a(CA_HALT) |-> ##[1:2] !o_cip_a)
    else $error("halt did not stop the scan");
  a_eos_end: assert property ($rose(o_eos_irq_a) |-> $past(o_cip_a))
    else $error("end of scan without a scan");
endmodule

bind adc_scan_sequencer adc_scan_checker adc_scan_checker_inst (.*);

// *** testbench/adc_conv_model.sv ***
// Converter core model: answers each request after a set number of cycles
`timescale 1ns/10ps
module adc_conv_model
  import adc_scan_pkg::*;
(
  input  wire logic       i_sys_clk,
  input  wire logic       i_rst,
  input  wire logic [3:0] i_wait,
  input  wire conv_req_t  i_req,
  output conv_rsp_t       o_rsp
);
  logic [3:0] cnt_q;

  // Data toggles outside done so a stale word never passes for a result
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= 4'h0;
      o_rsp <= '0;
    end else begin
      o_rsp.done <= 1'b0;
      o_rsp.data <= ~o_rsp.data;
      if (i_req.req && !o_rsp.done) begin
        cnt_q <= cnt_q + 4'h1;
        if (cnt_q >= i_wait) begin
          cnt_q <= 4'h0;
          o_rsp <= {1'b1, i_req.diff, i_req.chan, i_req.slot, 5'h15};
        end
      end
    end
  end
endmodule

// *** testbench/testbench.sv ***
// Testbench: register access and scan scenarios for the scan sequencer
`timescale 1ns/10ps
module testbench
  import adc_scan_pkg::*;
;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] e;
  } row_t;
  logic        clk, rst, hwrite, sync_a, hrdy, b_seen;
  logic        cip_a, cip_b, irq_a, irq_b;
  logic [1:0]  htrans;
  logic [3:0]  wa, wb;
  logic [31:0] haddr, hwdata, hrdata, r;
  conv_req_t   qa, qb;
  conv_rsp_t   pa, pb;
  int          err_count, cmp_count;
  row_t        rows [5] = '{'{OFS_CTRL_A, 32'h5}, '{OFS_CTRL_B, 32'h1},
    '{OFS_STATUS, 32'h30}, '{OFS_DIS, 32'h0}, '{8'h1C, 32'h0}};

  adc_scan_sequencer adc_scan_sequencer_inst (
    .i_sys_clk(clk), .i_rst(rst), .i_hsel(1'b1), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
    .i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy),
    .o_hresp(), .o_hrdata(hrdata), .i_sync_a(sync_a), .i_sync_b(1'b0),
    .i_conv_a(pa), .i_conv_b(pb), .o_conv_a(qa), .o_conv_b(qb),
    .o_cip_a(cip_a), .o_cip_b(cip_b), .o_eos_irq_a(irq_a),
    .o_eos_irq_b(irq_b));
  adc_conv_model adc_conv_model_inst_a (.i_sys_clk(clk), .i_rst(rst),
    .i_wait(wa), .i_req(qa), .o_rsp(pa));
  adc_conv_model adc_conv_model_inst_b (.i_sys_clk(clk), .i_rst(rst),
    .i_wait(wb), .i_req(qb), .o_rsp(pb));

  // ==========
  // Helpers
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) if (qb.req) b_seen <= 1'b1;

  // Pair 1 is differential in every scenario whose results are checked
  function automatic logic [31:0] er(input logic [31:0] lst, input int k);
    logic [2:0] c;
    c = 3'(lst >> (4 * (k % 4)));
    er = {17'h0, 1'(4'h2 >> c[2:1]), c, 3'(k), 5'h15, 3'h0};
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("wrong value at %0t: saw %h, want %h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    do begin @(posedge clk); end while (!hrdy);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge clk); end while (!hrdy);
    r = hrdata;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(r, e);
  endtask
  // A scan that never ends is left to the watchdog
  task automatic idle();
    repeat (2) @(posedge clk);
    while (cip_a || cip_b) begin @(posedge clk); end
    @(posedge clk);
  endtask
  task automatic pulse();
    sync_a <= 1'b1;
    repeat (2) @(posedge clk);
    sync_a <= 1'b0;
    repeat (4) @(posedge clk);
  endtask
  task automatic print_verdict();
    if (err_count == 0 && cmp_count > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // ==========
  // Scenarios
  initial begin
    rst = 1'b1; haddr = '0; htrans = '0; hwrite = 1'b0; hwdata = '0;
    sync_a = 1'b0; wa = 4'h9; wb = 4'h3; b_seen = 1'b0;
    err_count = 0; cmp_count = 0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    foreach (rows[i]) rd(rows[i].a, rows[i].e);
    bus(1'b1, OFS_LIST_L, 32'h521);
    bus(1'b1, OFS_DIS, 32'h08);
    bus(1'b1, OFS_CTRL_A, 32'hA20);
    idle();
    chk(32'(irq_a), 32'h1);
    chk(32'(b_seen), 32'h0);
    for (int k = 0; k < 4; k++)
      rd(OFS_RES0 + 8'(4 * k), k < 3 ? er(32'h521, k) : 32'h0);
    bus(1'b1, OFS_CTRL_A, 32'h600);
    repeat (3) @(posedge clk);
    chk(32'(cip_a), 32'h0);
    wa <= 4'h0;
    bus(1'b1, OFS_DIS, 32'hFE);
    bus(1'b1, OFS_CTRL_A, 32'h202);
    repeat (50) @(posedge clk);
    chk(32'(cip_a), 32'h1);
    bus(1'b1, OFS_CTRL_A, 32'h402);
    repeat (3) @(posedge clk);
    chk(32'(cip_a), 32'h0);
    bus(1'b1, OFS_STATUS, 32'hC);
    bus(1'b1, OFS_CTRL_B, 32'h0);
    bus(1'b1, OFS_LIST_H, 32'h56);
    bus(1'b1, OFS_DIS, 32'h40);
    bus(1'b1, OFS_CTRL_A, 32'h825);
    bus(1'b1, OFS_CTRL_B, 32'h14);
    idle();
    chk(32'(irq_b), 32'h1);
    chk(32'(irq_a), 32'h0);
    for (int k = 4; k < 7; k++)
      rd(OFS_RES0 + 8'(4 * k), k < 6 ? er(32'h56, k) : 32'h0);
    wa <= 4'h9;
    bus(1'b1, OFS_DIS, 32'hFE);
    bus(1'b1, OFS_CTRL_A, 32'h120);
    pulse();
    chk(32'(cip_a), 32'h1);
    idle();
    pulse();
    chk(32'(cip_a), 32'h0);
    idle();
    bus(1'b1, OFS_CTRL_A, 32'h120);
    pulse();
    chk(32'(cip_a), 32'h1);
    idle();
    bus(1'b1, OFS_CTRL_B, 32'h1);
    bus(1'b1, OFS_LIST_L, 32'h13);
    bus(1'b1, OFS_LIST_H, 32'h45);
    bus(1'b1, OFS_DIS, 32'h40);
    bus(1'b1, OFS_POWER, 32'h1001);
    bus(1'b1, OFS_CTRL_A, 32'h225);
    repeat (3) @(posedge clk);
    chk(32'({cip_a, cip_b, qa.req}), 32'h6);
    idle();
    for (int k = 0; k < 6; k++)
      if (k % 4 < 2)
        rd(OFS_RES0 + 8'(4 * k), er(k < 4 ? 32'h13 : 32'h45, k));
    print_verdict();
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    print_verdict();
  end
endmodule
